// File: pkg/isr_pkg.sv
/*
  Shared constants for the instrument status reporting block: bit positions,
  masks and reset values of the event, enable and status byte registers.
  Assumes a single 20 MHz clock domain; no timing counts are needed.
*/
package isr_pkg;
  localparam int unsigned CLK_MHZ = 20;
  // Standard event register bit positions
  localparam int unsigned SE_OPC = 0;
  localparam int unsigned SE_QRY = 2;
  localparam int unsigned SE_DEV = 3;
  localparam int unsigned SE_EXE = 4;
  localparam int unsigned SE_CMD = 5;
  localparam int unsigned SE_PON = 7;
  localparam logic [7:0] SE_VALID_MASK = 8'hbd;
  localparam logic [7:0] SE_ERR_MASK   = 8'h3c;
  // Questionable register bit positions
  localparam int unsigned QS_FAN  = 4;
  localparam int unsigned QS_OREG = 13;
  localparam logic [15:0] QS_VALID_MASK = 16'h2010;
  // Status byte bit positions
  localparam int unsigned SB_QUES = 3;
  localparam int unsigned SB_MAV  = 4;
  localparam int unsigned SB_ESB  = 5;
  localparam int unsigned SB_RQS  = 6;
  localparam logic [7:0] SB_SUM_MASK = 8'h38;
  // Regulation mode codes of the condition query
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_CC    = 2'h1;
  localparam logic [1:0] MODE_CV    = 2'h2;
  localparam logic [1:0] MODE_UNREG = 2'h3;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [1:0]
  {
    ISR_SRQ_IDLE = 2'b00,
    ISR_SRQ_REQ  = 2'b01,
    ISR_SRQ_HELD = 2'b10
  } isr_srq_state_t;
endpackage

// File: logic/isr_event_reg.sv
/*
  Generic latched event register with enable mask and summary output.
  Assumes set, clear and query strobes are synchronous to clk.
*/
`timescale 1ns/1ps
module isr_event_reg #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] VALID = '1
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] set_bits,
  input  wire logic         clear,
  input  wire logic         query,
  input  wire logic         en_wr,
  input  wire logic [W-1:0] en_wdata,
  input  wire logic         en_clr_pwr,
  output logic      [W-1:0] event_r,
  output logic      [W-1:0] enable_r,
  output logic              summary
);
  wire [W-1:0] set_v     = set_bits & VALID;
  wire         clr_any   = clear | query;
  wire [W-1:0] event_nxt = (clr_any ? '0 : event_r) | set_v;

  // Set wins over the clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      event_r <= '0;
    else
      event_r <= event_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      enable_r <= '0;
    else if (en_wr)
      enable_r <= en_wdata & VALID;
    else if (en_clr_pwr)
      enable_r <= '0;
  end

  assign summary = |(event_r & enable_r);

  AST_LATCH: assert property (@(posedge clk) disable iff (rst)
    (!clear && !query) |=> ((event_r & $past(event_r)) == $past(event_r)))
    else $error("event bit dropped without clear");
endmodule

// File: logic/isr_srq_ctrl.sv
/*
  Request-service bit control and SRQ line drive.
  Assumes poll and summary-read strobes are synchronous one-cycle pulses.
*/
`timescale 1ns/1ps
module isr_srq_ctrl
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic req_cond,
  input  wire logic serial_poll,
  input  wire logic cause_read,
  input  wire logic clear_all,
  output logic      rqs_r
);
  import isr_pkg::*;
  isr_srq_state_t state_r;
  isr_srq_state_t state_nxt;

  // A request needs a new rising condition after a poll, so it does not refire at once
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ISR_SRQ_IDLE: if (req_cond && !clear_all) state_nxt = ISR_SRQ_REQ;
      ISR_SRQ_REQ:
        if (clear_all || cause_read) state_nxt = ISR_SRQ_IDLE;
        else if (serial_poll) state_nxt = ISR_SRQ_HELD;
      ISR_SRQ_HELD: if (!req_cond || clear_all) state_nxt = ISR_SRQ_IDLE;
      default: state_nxt = ISR_SRQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_r <= ISR_SRQ_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rqs_r <= 1'b0;
    else
      rqs_r <= (state_nxt == ISR_SRQ_REQ);
  end
endmodule

// File: logic/isr_top.sv
/*
  Status reporting of a three-output instrument: standard event and
  questionable registers, enable masks, status byte, request service and SRQ.
  Assumes a command parser on clk issues one-cycle strobes; condition inputs
  come from the instrument and pass a two-flop synchroniser.
*/
`timescale 1ns/1ps

//
// Contract
// - Condition query gives two bits: 2 CV, 1 CC, 3 unregulated, 0 off.
// - Questionable event register clears on clear-status and when queried.
// - Questionable enable clears only by writing zero; weight 16 enables fan.
// - Enabled standard event bits OR into status byte bit 5.
// - Error-type standard events push an error queue entry.
// - Standard event layout 0,2,3,4,5,7; bits 1 and 6 read zero.
// - Query error set on empty read, unread query overrun, or both buffers full.
// - Power-on bit set when power cycled since last read or clear.
// - Standard event register clears on clear-status and when queried.
// - Standard event enable clears on zero write or power-on with setting 1.
// - Message-available bit 4 follows buffered query data immediately.
// - Summary bits are combinational; clearing event clears summary.
// - Status byte: bits 3,4,5,6 used; others read zero.
// - Clear-status clears status byte; event query clears only bit 5; the code keeps bit 4 on clear-status, clears bit 6 on a causing query.
// - Request enable clears on zero write or power-on with setting 1.
// - Enabled summaries set request-service bit 6 and drive SRQ.
// - Request-service clears only by serial poll or reading causing register; the code also clears it on clear-status.
// - Serial poll returns status byte, clears bit 6 only, never stalls.
// - Queries return binary-weighted sum of set bits.
// - Event bits latch until cleared; reset command and device clear keep them.
// - Enable registers mask event bits into summaries; reading does not clear.
// - Questionable bit 4 fan fault, bit 13 output-regulation summary.
module isr_top
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        fan_fault_in,
  input  wire logic [2:0]  output_regulation_summary,
  input  wire logic [1:0]  reg_mode_in,
  input  wire logic        opc_done,
  input  wire logic        dev_err,
  input  wire logic        exe_err,
  input  wire logic        cmd_err,
  input  wire logic        rd_empty_obuf,
  input  wire logic        unread_overrun,
  input  wire logic        bufs_full,
  input  wire logic        power_cycled,
  input  wire logic        psc_clear,
  input  wire logic        obuf_has_data,
  input  wire logic        cls_cmd,
  input  wire logic        se_query,
  input  wire logic        qs_query,
  input  wire logic        ese_wr,
  input  wire logic [7:0]  ese_wdata,
  input  wire logic        qse_wr,
  input  wire logic [15:0] qse_wdata,
  input  wire logic        sre_wr,
  input  wire logic [7:0]  sre_wdata,
  input  wire logic        serial_poll,
  output logic [7:0]       status_byte_q,
  output logic [7:0]       poll_byte_q,
  output logic [7:0]       se_flags_q,
  output logic [7:0]       se_enable_q,
  output logic [15:0]      qs_flags_q,
  output logic [15:0]      qs_enable_q,
  output logic [7:0]       sre_q,
  output logic [1:0]       cond_q,
  output logic             err_push_q,
  output logic             srq_q
);
  import isr_pkg::*;

  logic [1:0]  meta_r;
  logic [1:0]  sync_r;
  logic [2:0]  oreg_meta_r;
  logic [2:0]  oreg_sync_r;
  logic [1:0]  mode_meta_r;
  logic [1:0]  mode_sync_r;
  logic [7:0]  se_ev;
  logic [7:0]  se_en;
  logic [15:0] qs_ev;
  logic [15:0] qs_en;
  logic        esb_sum;
  logic        ques_sum;
  logic        rqs;
  logic [7:0]  sre_r;
  logic        pwr_seen_r;
  logic        pon_pend_r;

  // Two-flop synchronisers for instrument-side conditions
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r      <= 2'h0;
      sync_r      <= 2'h0;
      oreg_meta_r <= 3'h0;
      oreg_sync_r <= 3'h0;
      mode_meta_r <= MODE_OFF;
      mode_sync_r <= MODE_OFF;
    end
    else
    begin
      meta_r      <= {power_cycled, fan_fault_in};
      sync_r      <= meta_r;
      oreg_meta_r <= output_regulation_summary;
      oreg_sync_r <= oreg_meta_r;
      mode_meta_r <= reg_mode_in;
      mode_sync_r <= mode_meta_r;
    end
  end

  // Power-on event is a one-cycle pulse after reset and on each rise of the synchronised power-cycled input
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwr_seen_r <= 1'b0;
      pon_pend_r <= 1'b1;
    end
    else
    begin
      pwr_seen_r <= sync_r[1];
      pon_pend_r <= sync_r[1] & ~pwr_seen_r;
    end
  end

  wire         qry_err_ev = rd_empty_obuf | unread_overrun | bufs_full;
  wire [7:0]   se_set;
  assign se_set[SE_OPC] = opc_done;
  assign se_set[1]      = 1'b0;
  assign se_set[SE_QRY] = qry_err_ev;
  assign se_set[SE_DEV] = dev_err;
  assign se_set[SE_EXE] = exe_err;
  assign se_set[SE_CMD] = cmd_err;
  assign se_set[6]      = 1'b0;
  assign se_set[SE_PON] = pon_pend_r;

  wire [15:0]  qs_set;
  assign qs_set = ({15'h0, sync_r[0]} << QS_FAN)
                | ({15'h0, |oreg_sync_r} << QS_OREG);

  wire         pwr_clr = pon_pend_r & psc_clear;

  // Standard event register and its mask
  isr_event_reg #(.W(8), .VALID(SE_VALID_MASK)) u_se
  (
    .clk        (clk),
    .rst        (rst),
    .set_bits   (se_set),
    .clear      (cls_cmd),
    .query      (se_query),
    .en_wr      (ese_wr),
    .en_wdata   (ese_wdata),
    .en_clr_pwr (pwr_clr),
    .event_r    (se_ev),
    .enable_r   (se_en),
    .summary    (esb_sum)
  );

  // Questionable register; its mask only clears by writing zero
  isr_event_reg #(.W(16), .VALID(QS_VALID_MASK)) u_qs
  (
    .clk        (clk),
    .rst        (rst),
    .set_bits   (qs_set),
    .clear      (cls_cmd),
    .query      (qs_query),
    .en_wr      (qse_wr),
    .en_wdata   (qse_wdata),
    .en_clr_pwr (1'b0),
    .event_r    (qs_ev),
    .enable_r   (qs_en),
    .summary    (ques_sum)
  );

  // One flag placed at its weight in a status byte
  function automatic logic [7:0] sb_bit(input logic flag, input int unsigned pos);
    sb_bit = 8'h00;
    sb_bit[pos[2:0]] = flag;
  endfunction

  // Summary bits are combinational so an event clear drops them at once
  wire [7:0] sb_sum;
  assign sb_sum = sb_bit(ques_sum, SB_QUES)
                | sb_bit(obuf_has_data, SB_MAV)
                | sb_bit(esb_sum, SB_ESB);
  wire       req_cond = |(sb_sum & sre_r & SB_SUM_MASK);
  wire       cause_rd = (se_query & sre_r[SB_ESB] & esb_sum)
                      | (qs_query & sre_r[SB_QUES] & ques_sum);

  isr_srq_ctrl u_srq
  (
    .clk         (clk),
    .rst         (rst),
    .req_cond    (req_cond),
    .serial_poll (serial_poll),
    .cause_read  (cause_rd),
    .clear_all   (cls_cmd),
    .rqs_r       (rqs)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sre_r <= RST_BYTE;
    else if (sre_wr)
      sre_r <= sre_wdata & SB_SUM_MASK;
    else if (pwr_clr)
      sre_r <= RST_BYTE;
  end

  wire [7:0] sb_full = sb_sum | sb_bit(rqs, SB_RQS);
  wire       err_ev  = |(se_set & SE_ERR_MASK);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_byte_q <= RST_BYTE;
      poll_byte_q   <= RST_BYTE;
      se_flags_q    <= RST_BYTE;
      se_enable_q   <= RST_BYTE;
      qs_flags_q    <= RST_WORD;
      qs_enable_q   <= RST_WORD;
      sre_q         <= RST_BYTE;
      cond_q        <= MODE_OFF;
      err_push_q    <= 1'b0;
      srq_q         <= 1'b0;
    end
    else
    begin
      status_byte_q <= sb_full;
      if (serial_poll)
        poll_byte_q <= sb_full;
      se_flags_q    <= se_ev;
      se_enable_q   <= se_en;
      qs_flags_q    <= qs_ev;
      qs_enable_q   <= qs_en;
      sre_q         <= sre_r;
      cond_q        <= mode_sync_r;
      err_push_q    <= err_ev;
      srq_q         <= rqs;
    end
  end

  AST_ERR_PUSH: assert property (@(posedge clk) disable iff (rst)
    (qry_err_ev | dev_err | exe_err | cmd_err) |=> err_push_q)
    else $error("error event without queue push");
  AST_SE_CLR: assert property (@(posedge clk) disable iff (rst)
    (se_query && !(|se_set)) |=> (se_ev == 8'h00))
    else $error("standard event not cleared by query");
  AST_QS_CLR: assert property (@(posedge clk) disable iff (rst)
    (cls_cmd && !(|qs_set)) |=> (qs_ev == 16'h0000))
    else $error("questionable not cleared by clear-status");
  AST_RSV: assert property (@(posedge clk) disable iff (rst)
    (se_flags_q[1] == 1'b0) && (se_flags_q[6] == 1'b0))
    else $error("reserved event bit set");
  AST_SB_ZERO: assert property (@(posedge clk) disable iff (rst)
    (status_byte_q & 8'h87) == 8'h00)
    else $error("reserved status byte bit set");
  AST_MAV: assert property (@(posedge clk) disable iff (rst)
    obuf_has_data |=> status_byte_q[SB_MAV])
    else $error("message available late");
  AST_QEN: assert property (@(posedge clk) disable iff (rst)
    (!qse_wr) |=> (qs_en == $past(qs_en)))
    else $error("questionable enable changed without write");
  AST_SRQ: assert property (@(posedge clk) disable iff (rst)
    rqs |=> srq_q)
    else $error("srq not following request service");
  AST_POLL: assert property (@(posedge clk) disable iff (rst)
    (serial_poll && rqs && !cls_cmd && !cause_rd) |=> !rqs)
    else $error("poll did not clear request service");
  AST_PSC: assert property (@(posedge clk) disable iff (rst)
    (pwr_clr && !ese_wr) |=> (se_en == 8'h00))
    else $error("event enable kept at power-on clear");

  // A fresh summary raises request service, and SRQ follows a cycle later
  sequence s_req_new;
    $rose(req_cond) && !$past(serial_poll) && !serial_poll && !cls_cmd && !cause_rd;
  endsequence

  sequence s_srq_up;
    rqs ##1 srq_q;
  endsequence

  AST_REQ_SRQ: assert property (@(posedge clk) disable iff (rst)
    s_req_new |=> s_srq_up)
    else $error("new request did not raise srq");
  AST_RQS_HOLD: assert property (@(posedge clk) disable iff (rst)
    (rqs && !serial_poll && !cause_rd && !cls_cmd) |=> rqs)
    else $error("request service dropped without poll or read");
  AST_POLL_BYTE: assert property (@(posedge clk) disable iff (rst)
    serial_poll |=> (poll_byte_q[SB_RQS] == $past(rqs)))
    else $error("poll byte lost request service bit");

  // Event bits are taken one cycle after their source is seen
  AST_OPC_SET: assert property (@(posedge clk) disable iff (rst)
    opc_done |=> se_ev[SE_OPC])
    else $error("operation complete not latched");
  AST_QYE_SET: assert property (@(posedge clk) disable iff (rst)
    qry_err_ev |=> se_ev[SE_QRY])
    else $error("query error not latched");
  AST_PON_SET: assert property (@(posedge clk) disable iff (rst)
    pon_pend_r |=> se_ev[SE_PON])
    else $error("power-on event not latched");
  AST_FAN_SET: assert property (@(posedge clk) disable iff (rst)
    sync_r[0] |=> qs_ev[QS_FAN])
    else $error("fan fault not latched");

  // Summary bits must track the mirrored registers exactly
  AST_ESB_OUT: assert property (@(posedge clk) disable iff (rst)
    status_byte_q[SB_ESB] == (|(se_flags_q & se_enable_q)))
    else $error("event summary bit does not match enabled events");
  AST_QUES_OUT: assert property (@(posedge clk) disable iff (rst)
    status_byte_q[SB_QUES] == (|(qs_flags_q & qs_enable_q)))
    else $error("questionable summary bit does not match enabled events");
  AST_MAV_LOW: assert property (@(posedge clk) disable iff (rst)
    !obuf_has_data |=> !status_byte_q[SB_MAV])
    else $error("message available kept with empty buffer");

  // Clears reach the mirrored status byte two cycles after the strobe
  AST_ESB_DROP: assert property (@(posedge clk) disable iff (rst)
    (se_query && !(|se_set)) |=> ##1 !status_byte_q[SB_ESB])
    else $error("event query did not drop summary bit");
  AST_SB_CLS: assert property (@(posedge clk) disable iff (rst)
    (cls_cmd && !(|se_set) && !(|qs_set)) ##1 !obuf_has_data |=> (status_byte_q == 8'h00))
    else $error("clear-status left status byte bits");
  AST_QS_QRY: assert property (@(posedge clk) disable iff (rst)
    (qs_query && !(|qs_set)) |=> (qs_ev == 16'h0000))
    else $error("questionable not cleared by query");
  AST_ESE_KEEP: assert property (@(posedge clk) disable iff (rst)
    (pon_pend_r && !psc_clear && !ese_wr) |=> (se_en == $past(se_en)))
    else $error("event enable lost at power-on without clear setting");
  AST_SRE_PSC: assert property (@(posedge clk) disable iff (rst)
    (pwr_clr && !sre_wr) |=> (sre_r == 8'h00))
    else $error("request enable kept at power-on clear");
endmodule

// File: testbench/isr_ctrl_model.sv
/*
  Bus controller model: issues command strobes, mask writes and serial
  polls to the status block, one command at a time, each one cycle wide.
  Assumes the block samples every strobe on the rising clock edge.
*/
`timescale 1ns/1ps
module isr_ctrl_model
(
  input  wire logic   clk,
  output logic        cls_cmd,
  output logic        se_query,
  output logic        qs_query,
  output logic        ese_wr,
  output logic        qse_wr,
  output logic        sre_wr,
  output logic        serial_poll,
  output logic [15:0] wdata
);
  initial
  begin
    {cls_cmd, se_query, qs_query, ese_wr, qse_wr, sre_wr, serial_poll} = 7'h00;
    wdata = 16'h0000;
  end

  task automatic send(input logic [6:0] s, input logic [15:0] d);
    // A poll too soon after a command may report stale conditions
    if (s[0])
      repeat (6) @(negedge clk);
    @(negedge clk);
    {cls_cmd, se_query, qs_query, ese_wr, qse_wr, sre_wr, serial_poll} = s;
    wdata = d;
    @(negedge clk);
    {cls_cmd, se_query, qs_query, ese_wr, qse_wr, sre_wr, serial_poll} = 7'h00;
    // Released data lines must not keep showing the last value
    wdata = ~d;
  endtask
endmodule

// File: testbench/isr_top_tb_top.sv
/*
  Self-checking bench for isr_top: drives instrument conditions, lets the
  controller model issue commands, compares status outputs to expectations.
  Assumes the design's stated latencies of at most six cycles.
*/
`timescale 1ns/1ps
module isr_top_tb_top;
  import isr_pkg::*;
  localparam logic [6:0] C_CLS = 7'h40, C_SEQ = 7'h20, C_QSQ = 7'h10, C_ESE = 7'h08;
  localparam logic [6:0] C_QSE = 7'h04, C_SRE = 7'h02, C_POLL = 7'h01;
  logic        clk, rst, fan, pcyc, psc, obuf, opc, dev, exe, cmd, rde, ovr, full;
  logic        cls, seq, qsq, esew, qsew, srew, poll, push, srq, saw_push;
  logic [2:0]  oreg;
  logic [1:0]  mode, cond;
  logic [15:0] wd, qsf, qse;
  logic [7:0]  sb, pb, sef, see, sre;
  int          n_fail, n_compared, cyc;

  isr_ctrl_model i_ctrl (.clk(clk), .cls_cmd(cls), .se_query(seq), .qs_query(qsq),
    .ese_wr(esew), .qse_wr(qsew), .sre_wr(srew), .serial_poll(poll), .wdata(wd));

  isr_top i_dut (.clk(clk), .rst(rst), .fan_fault_in(fan), .output_regulation_summary(oreg),
    .reg_mode_in(mode), .opc_done(opc), .dev_err(dev), .exe_err(exe), .cmd_err(cmd),
    .rd_empty_obuf(rde), .unread_overrun(ovr), .bufs_full(full), .power_cycled(pcyc),
    .psc_clear(psc), .obuf_has_data(obuf), .cls_cmd(cls), .se_query(seq), .qs_query(qsq),
    .ese_wr(esew), .ese_wdata(wd[7:0]), .qse_wr(qsew), .qse_wdata(wd), .sre_wr(srew),
    .sre_wdata(wd[7:0]), .serial_poll(poll), .status_byte_q(sb), .poll_byte_q(pb),
    .se_flags_q(sef), .se_enable_q(see), .qs_flags_q(qsf), .qs_enable_q(qse), .sre_q(sre),
    .cond_q(cond), .err_push_q(push), .srq_q(srq));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Error queue pushes may be short pulses, so remember any one seen
  always @(posedge clk)
  begin
    if (push === 1'b1)
      saw_push <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (6) @(negedge clk);
  endtask

  // Event sources in order opc, dev, exe, cmd, empty read, overrun, full
  task automatic ev(input logic [6:0] v);
    @(negedge clk);
    {opc, dev, exe, cmd, rde, ovr, full} = v;
    @(negedge clk);
    {opc, dev, exe, cmd, rde, ovr, full} = 7'h00;
    settle();
  endtask

  initial
  begin
    {fan, pcyc, psc, obuf, oreg, mode} = 9'h000;
    {opc, dev, exe, cmd, rde, ovr, full} = 7'h00;
    rst = 1'b1;
    saw_push = 1'b0;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    settle();
    chk(16'(sef), 16'h0080);
    chk(16'(sb), 16'h0000);
    i_ctrl.send(C_SEQ, 16'h0000);
    settle();
    chk(16'(sef), 16'h0000);
    i_ctrl.send(C_ESE, 16'h00ff);
    i_ctrl.send(C_SRE, 16'h00ff);
    settle();
    chk(16'(see), 16'h00bd);
    chk(16'(sre), 16'h0038);
    ev(7'h78);
    chk(16'(sef), 16'h0039);
    chk(16'(sb), 16'h0060);
    chk(16'(srq), 16'h0001);
    chk(16'(saw_push), 16'h0001);
    i_ctrl.send(C_POLL, 16'h0000);
    settle();
    chk(16'(pb), 16'h0060);
    chk(16'(sb), 16'h0020);
    chk(16'(srq), 16'h0000);
    i_ctrl.send(C_SEQ, 16'h0000);
    settle();
    chk(16'(sb), 16'h0000);
    chk(16'(see), 16'h00bd);
    for (int i = 0; i < 3; i++)
    begin
      ev(7'h04 >> i);
      chk(16'(sef), 16'h0004);
      i_ctrl.send(C_SEQ, 16'h0000);
      settle();
    end
    i_ctrl.send(C_QSE, 16'hffff);
    settle();
    chk(qse, 16'h2010);
    fan = 1'b1;
    oreg = 3'h2;
    settle();
    fan = 1'b0;
    oreg = 3'h0;
    settle();
    chk(qsf, 16'h2010);
    chk(16'(sb), 16'h0048);
    i_ctrl.send(C_QSQ, 16'h0000);
    settle();
    chk(qsf, 16'h0000);
    chk(16'(sb), 16'h0000);
    obuf = 1'b1;
    settle();
    chk(16'(sb), 16'h0050);
    obuf = 1'b0;
    settle();
    chk(16'(sb), 16'h0040);
    i_ctrl.send(C_POLL, 16'h0000);
    settle();
    chk(16'(pb), 16'h0040);
    for (int m = 0; m < 4; m++)
    begin
      mode = 2'(m);
      settle();
      chk(16'(cond), 16'(m));
    end
    ev(7'h08);
    i_ctrl.send(C_CLS, 16'h0000);
    settle();
    chk(16'(sef), 16'h0000);
    chk(16'(sb), 16'h0000);
    i_ctrl.send(C_QSE, 16'h0000);
    settle();
    chk(qse, 16'h0000);
    pcyc = 1'b1;
    settle();
    pcyc = 1'b0;
    settle();
    chk(16'(sef), 16'h0080);
    chk(16'(see), 16'h00bd);
    chk(16'(sre), 16'h0038);
    psc = 1'b1;
    pcyc = 1'b1;
    settle();
    chk(16'(see), 16'h0000);
    chk(16'(sre), 16'h0000);
    saw_push = 1'b0;
    ev(7'h40);
    chk(16'(sef), 16'h0081);
    chk(16'(saw_push), 16'h0000);
    summarize();
  end
endmodule
